// ===== design/ssps_pkg.sv
// How it works
// - port runs SPI or I2C, never both
// - eight bits shift out and in together
// - data out, data in, clock pins
// - slave select used only in slave mode
// - slave select high resets slave logic
// - clock-edge one slave needs slave select
// - slave select high forces sdo direction readback
// - I2C status bit 2 holds direction
`default_nettype none
package ssps_pkg;
	localparam logic [2:0] SSPS_ADDR_STAT = 3'h0;
	localparam logic [2:0] SSPS_ADDR_CTRL = 3'h1;
	localparam logic [2:0] SSPS_ADDR_BUF = 3'h2;
	localparam logic [2:0] SSPS_ADDR_IRQ = 3'h3;
	localparam logic [2:0] SSPS_ADDR_MASK = 3'h4;
	localparam logic [2:0] SSPS_ADDR_DIR = 3'h5;
	localparam logic [3:0] SSPS_M_DIV4 = 4'h0;
	localparam logic [3:0] SSPS_M_DIV16 = 4'h1;
	localparam logic [3:0] SSPS_M_DIV64 = 4'h2;
	localparam logic [3:0] SSPS_M_TMR = 4'h3;
	localparam logic [3:0] SSPS_M_SLV_SS = 4'h4;
	localparam logic [3:0] SSPS_M_SLV = 4'h5;
	localparam int SSPS_STAT_SMP = 7;
	localparam int SSPS_STAT_CKE = 6;
	localparam int SSPS_STAT_RW = 2;
	localparam int SSPS_STAT_BF = 0;
	localparam int SSPS_CTRL_WCOL = 7;
	localparam int SSPS_CTRL_OV = 6;
	localparam int SSPS_CTRL_EN = 5;
	localparam int SSPS_CTRL_CKP = 4;
	localparam int SSPS_IRQ_DONE = 0;
	localparam int SSPS_IRQ_WCOL = 1;
	localparam int SSPS_IRQ_OV = 2;
	localparam int SSPS_DIR_SDO = 7;
	localparam int SSPS_DIR_SCK = 6;
	localparam logic [7:0] SSPS_RESET_BYTE = 8'h00;
	localparam logic [7:0] SSPS_DIR_RESET = 8'hff;
	// half periods minus one, in system cycles: fosc/4 style divisors
	localparam logic [5:0] SSPS_HALF_DIV4 = 6'h01;
	localparam logic [5:0] SSPS_HALF_DIV16 = 6'h07;
	localparam logic [5:0] SSPS_HALF_DIV64 = 6'h1f;
	localparam logic [3:0] SSPS_BITS = 4'h8;
	typedef enum logic [2:0] {
		SSPS_IDLE = 3'b001,
		SSPS_LEAD = 3'b010,
		SSPS_TRAIL = 3'b100
	} ssps_state_t;
endpackage : ssps_pkg
`default_nettype wire

// ===== design/ssps_spi.sv
`default_nettype none
module ssps_spi
	import ssps_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	// register port
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// link pins
	input wire logic SDI,
	output logic SDO,
	output logic SDO_OE,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE,
	input wire logic SS_N,
	// external timer tick and I2C direction
	input wire logic TMR_TICK,
	input wire logic I2C_RW,
	input wire logic I2C_ADDR_MATCH,
	input wire logic I2C_CLR_RW,
	// interrupt
	output logic IRQ
);
	logic [7:0] stat_reg, ctrl_reg, buf_reg, irq_reg, mask_reg, dir_reg;
	logic [7:0] sr_reg, rdata_reg;
	logic [3:0] cnt_reg;
	logic [5:0] div_reg;
	logic sdi_s1, sdi_s2, sck_s1, sck_s2, ss_s1, ss_s2, sck_d;
	logic sck_out_reg, sdo_reg, smp_bit;
	ssps_state_t st_reg;
	logic en, slave, ss_mode, ss_high, spi_mode, busy, tick;
	logic sck_rise, sck_fall, shift_edge, sample_edge, done;
	logic buf_wr, buf_rd, wcol_ev, ov_ev, cke_bad;

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d <= 1'b0;
			ss_s1 <= 1'b1;
			ss_s2 <= 1'b1;
		end else if (CE) begin
			sdi_s1 <= SDI;
			sdi_s2 <= sdi_s1;
			sck_s1 <= SCK_IN;
			sck_s2 <= sck_s1;
			sck_d <= sck_s2;
			ss_s1 <= SS_N;
			ss_s2 <= ss_s1;
		end
	end

	////////////////////////////////////////////////////////////////
	// mode decode
	assign en = ctrl_reg[SSPS_CTRL_EN];
	assign spi_mode = (ctrl_reg[3:0] <= SSPS_M_SLV);
	assign slave = (ctrl_reg[3:0] == SSPS_M_SLV_SS) ||
		(ctrl_reg[3:0] == SSPS_M_SLV);
	assign ss_mode = ctrl_reg[3:0] == SSPS_M_SLV_SS;
	assign ss_high = en && ss_mode && ss_s2;
	// clock-edge one without select control is not allowed: hold idle
	assign cke_bad = (ctrl_reg[3:0] == SSPS_M_SLV) &&
		stat_reg[SSPS_STAT_CKE];
	assign busy = st_reg != SSPS_IDLE;
	assign buf_wr = WR && ADDR == SSPS_ADDR_BUF;
	assign buf_rd = RD && ADDR == SSPS_ADDR_BUF;
	assign wcol_ev = buf_wr && busy;
	// slave edge stream: idle level per clock polarity
	assign sck_rise = sck_s2 && !sck_d;
	assign sck_fall = !sck_s2 && sck_d;
	// clock-edge bit: 1 shifts on active-to-idle edge
	assign shift_edge = (stat_reg[SSPS_STAT_CKE] ^
		ctrl_reg[SSPS_CTRL_CKP]) ? sck_fall : sck_rise;
	assign sample_edge = (stat_reg[SSPS_STAT_CKE] ^
		ctrl_reg[SSPS_CTRL_CKP]) ? sck_rise : sck_fall;
	// slave samples at middle regardless of the stored bit
	assign smp_bit = slave ? 1'b0 : stat_reg[SSPS_STAT_SMP];

	////////////////////////////////////////////////////////////////
	// master bit clock divider
	always_comb begin
		case (ctrl_reg[3:0])
		SSPS_M_DIV4: tick = div_reg == SSPS_HALF_DIV4;
		SSPS_M_DIV16: tick = div_reg == SSPS_HALF_DIV16;
		SSPS_M_DIV64: tick = div_reg == SSPS_HALF_DIV64;
		SSPS_M_TMR: tick = TMR_TICK;
		default: tick = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!NRST)
			div_reg <= 6'h00;
		else if (CE) begin
			if (!busy || tick || slave)
				div_reg <= 6'h00;
			else
				div_reg <= div_reg + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// shift engine, msb first, eight bits each way
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st_reg <= SSPS_IDLE;
			sr_reg <= SSPS_RESET_BYTE;
			cnt_reg <= 4'h0;
			sck_out_reg <= 1'b0;
			sdo_reg <= 1'b0;
		end else if (CE) begin
			if (!en || !spi_mode || ss_high || cke_bad) begin
				st_reg <= SSPS_IDLE;
				cnt_reg <= 4'h0;
				sck_out_reg <= ctrl_reg[SSPS_CTRL_CKP];
			end else if (buf_wr && !busy) begin
				sr_reg <= WDATA;
				sdo_reg <= WDATA[7];
				cnt_reg <= 4'h0;
				st_reg <= slave ? SSPS_TRAIL : SSPS_LEAD;
			end else if (slave && busy) begin
				if (sample_edge) begin
					sr_reg <= {sr_reg[6:0], sdi_s2};
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == SSPS_BITS - 4'h1)
						st_reg <= SSPS_IDLE;
				end else if (shift_edge) begin
					sdo_reg <= sr_reg[7];
				end
			end else if (busy && tick) begin
				case (st_reg)
				SSPS_LEAD: begin
					sck_out_reg <= ~sck_out_reg;
					if (!smp_bit)
						sr_reg <= {sr_reg[6:0], sdi_s2};
					st_reg <= SSPS_TRAIL;
				end
				SSPS_TRAIL: begin
					sck_out_reg <= ~sck_out_reg;
					if (smp_bit)
						sr_reg <= {sr_reg[6:0], sdi_s2};
					sdo_reg <= smp_bit ? sr_reg[6] : sr_reg[7];
					cnt_reg <= cnt_reg + 4'h1;
					st_reg <= (cnt_reg == SSPS_BITS - 4'h1) ?
						SSPS_IDLE : SSPS_LEAD;
				end
				default: st_reg <= SSPS_IDLE;
				endcase
			end else if (!busy) begin
				sck_out_reg <= ctrl_reg[SSPS_CTRL_CKP];
			end
		end
	end

	assign done = busy && ((slave && sample_edge) || (!slave && tick &&
		st_reg == SSPS_TRAIL)) && cnt_reg == SSPS_BITS - 4'h1 &&
		en && spi_mode && !ss_high && !cke_bad;
	assign ov_ev = done && slave && stat_reg[SSPS_STAT_BF];

	////////////////////////////////////////////////////////////////
	// receive buffer and buffer full
	always_ff @(posedge CLK) begin
		if (!NRST)
			buf_reg <= SSPS_RESET_BYTE;
		else if (CE && done && !ov_ev)
			buf_reg <= slave ? {sr_reg[6:0], sdi_s2} :
				(smp_bit ? {sr_reg[6:0], sdi_s2} : sr_reg);
	end

	always_ff @(posedge CLK) begin
		if (!NRST)
			stat_reg <= SSPS_RESET_BYTE;
		else if (CE) begin
			if (WR && ADDR == SSPS_ADDR_STAT) begin
				stat_reg[SSPS_STAT_SMP] <= WDATA[SSPS_STAT_SMP];
				stat_reg[SSPS_STAT_CKE] <= WDATA[SSPS_STAT_CKE];
			end
			if (done)
				stat_reg[SSPS_STAT_BF] <= 1'b1;
			else if (buf_rd)
				stat_reg[SSPS_STAT_BF] <= 1'b0;
			if (I2C_ADDR_MATCH && !spi_mode)
				stat_reg[SSPS_STAT_RW] <= I2C_RW;
			else if (I2C_CLR_RW || !en)
				stat_reg[SSPS_STAT_RW] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// control, interrupt and direction registers
	always_ff @(posedge CLK) begin
		if (!NRST)
			ctrl_reg <= SSPS_RESET_BYTE;
		else if (CE) begin
			if (WR && ADDR == SSPS_ADDR_CTRL)
				ctrl_reg <= WDATA;
			if (wcol_ev)
				ctrl_reg[SSPS_CTRL_WCOL] <= 1'b1;
			if (ov_ev)
				ctrl_reg[SSPS_CTRL_OV] <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			irq_reg <= SSPS_RESET_BYTE;
			mask_reg <= SSPS_RESET_BYTE;
		end else if (CE) begin
			if (WR && ADDR == SSPS_ADDR_MASK)
				mask_reg <= WDATA;
			irq_reg <= (irq_reg & ~((WR && ADDR == SSPS_ADDR_IRQ) ?
				WDATA : 8'h00)) | {5'h00, ov_ev, wcol_ev, done};
		end
	end

	// read-modify-write while select high sets the sdo direction bit
	always_ff @(posedge CLK) begin
		if (!NRST)
			dir_reg <= SSPS_DIR_RESET;
		else if (CE && WR && ADDR == SSPS_ADDR_DIR)
			dir_reg <= WDATA;
	end

	////////////////////////////////////////////////////////////////
	// register reads, data one cycle later
	always_ff @(posedge CLK) begin
		if (!NRST)
			rdata_reg <= SSPS_RESET_BYTE;
		else if (CE && RD) begin
			case (ADDR)
			SSPS_ADDR_STAT: rdata_reg <= stat_reg;
			SSPS_ADDR_CTRL: rdata_reg <= ctrl_reg;
			SSPS_ADDR_BUF: rdata_reg <= buf_reg;
			SSPS_ADDR_IRQ: rdata_reg <= irq_reg;
			SSPS_ADDR_MASK: rdata_reg <= mask_reg;
			SSPS_ADDR_DIR: begin
				rdata_reg <= dir_reg;
				if (ss_high)
					rdata_reg[SSPS_DIR_SDO] <= 1'b1;
			end
			default: rdata_reg <= SSPS_RESET_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// pin drive
	assign RDATA = rdata_reg;
	assign SDO = sdo_reg;
	assign SDO_OE = en && spi_mode && !dir_reg[SSPS_DIR_SDO] &&
		!ss_high;
	assign SCK_OUT = sck_out_reg;
	assign SCK_OE = en && spi_mode && !slave &&
		!dir_reg[SSPS_DIR_SCK];
	assign IRQ = |(irq_reg & mask_reg);
endmodule : ssps_spi
`default_nettype wire

// ===== tb/ssps_chk.sv
`default_nettype none
module ssps_chk
	import ssps_pkg::*;
(
	// clock and register port
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	// link pins and interrupt
	input wire logic SDO,
	input wire logic SDO_OE,
	input wire logic SCK_OUT,
	input wire logic SCK_OE,
	input wire logic SS_N,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl_reg;
	logic [7:0] msk_reg;
	logic [5:0] q_reg;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	// shadow of control, mask and time since last buffer write
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ctl_reg <= 8'h00;
			msk_reg <= 8'h00;
			q_reg <= 6'h3f;
		end else begin
			if (WR && ADDR == SSPS_ADDR_CTRL) ctl_reg <= WDATA;
			if (WR && ADDR == SSPS_ADDR_MASK) msk_reg <= WDATA;
			if (WR && ADDR == SSPS_ADDR_BUF) q_reg <= 6'h00;
			else if (q_reg != 6'h3f) q_reg <= q_reg + 6'h01;
		end
	end
	sequence sel_high;
		(ctl_reg == 8'h24 && SS_N)[*4];
	endsequence
	sequence buf_then_stat;
		(RD && ADDR == SSPS_ADDR_BUF) ##2 (RD && ADDR == SSPS_ADDR_STAT);
	endsequence
	reset_quiet_a: assert property ($rose(NRST) |-> !IRQ && !SCK_OE && !SDO_OE)
		else $error("outputs active after reset");
	unmapped_zero_a: assert property (RD && ADDR > 3'h5 |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	slave_no_clock_a: assert property (
		(ctl_reg[5] && ctl_reg[3:1] == 3'h2)[*2] |-> !SCK_OE)
		else $error("slave drives clock");
	mask_blocks_irq_a: assert property ((msk_reg == 8'h00)[*2] |-> !IRQ)
		else $error("masked interrupt raised");
	half_period_a: assert property (
		ctl_reg == 8'h20 && $changed(SCK_OUT) |=> $stable(SCK_OUT))
		else $error("clock half period short");
	msb_first_a: assert property (WR && ADDR == SSPS_ADDR_BUF &&
		ctl_reg == 8'h20 && q_reg == 6'h3f |=> SDO == $past(WDATA[7]))
		else $error("first bit not msb");
	bf_cleared_a: assert property (buf_then_stat |=> !RDATA[0])
		else $error("buffer full after read");
	dir_readback_a: assert property (sel_high ##0
		(RD && ADDR == SSPS_ADDR_DIR) |=> RDATA[7])
		else $error("direction readback low");
endmodule // ssps_chk
bind ssps_spi ssps_chk ssps_chk_inst(.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SDO(SDO),
	.SDO_OE(SDO_OE), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SS_N(SS_N),
	.IRQ(IRQ));
`default_nettype wire

// ===== tb/ssps_peer.sv
`default_nettype none
module ssps_peer (
	// link side
	input wire logic sck,
	input wire logic sdo,
	input wire logic rst_n,
	// data
	input wire logic [7:0] tx,
	output logic sdi,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] n;
	assign sdi = tx[3'h7 - n];
	always @(posedge sck) rx <= {rx[6:0], sdo};
	always @(negedge sck or negedge rst_n) begin
		if (!rst_n) n <= 3'h0;
		else n <= n + 3'h1;
	end
endmodule // ssps_peer
`default_nettype wire

// ===== tb/ssps_spi_test.sv
`default_nettype none
module ssps_spi_test
	import ssps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, wr, rd, sck_in, ss_n, slv, bsdi;
	logic [2:0] addr;
	logic [7:0] wdata, ptx, d, v;
	wire logic [7:0] rdata, prx;
	wire logic sdo, sdo_oe, sck_out, sck_oe, irq, psdi, sdi;
	int n_errors, cmp_count;
	always #5 clk = ~clk;
	assign sdi = slv ? bsdi : psdi;
	ssps_spi ssps_spi_inst(.CLK(clk), .NRST(nrst), .CE(1'b1), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SDI(sdi), .SDO(sdo),
		.SDO_OE(sdo_oe), .SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(sck_oe),
		.SS_N(ss_n), .TMR_TICK(1'b0), .I2C_RW(1'b0), .I2C_ADDR_MATCH(1'b0),
		.I2C_CLR_RW(1'b0), .IRQ(irq));
	ssps_peer ssps_peer_inst(.sck(sck_out), .sdo(sdo), .rst_n(nrst),
		.tx(ptx), .sdi(psdi), .rx(prx));
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] irq_exp(input logic c);
		return {6'h00, c, 1'b1};
	endfunction
	task automatic chk(input string s, input logic [7:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input string s, input logic [2:0] a,
		input logic [7:0] m, e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
		chk(s, e, v & m);
	endtask
	task automatic sbyte(input logic [7:0] x);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			bsdi <= x[i];
			repeat (4) @(posedge clk);
			sck_in <= 1'b1;
			repeat (4) @(posedge clk);
			sck_in <= 1'b0;
		end
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize();
	end
	initial begin
		{clk, nrst, wr, rd, sck_in, slv, bsdi} = 7'h00;
		{addr, wdata, ptx, n_errors, cmp_count} = '0;
		ss_n = 1'b1;
		void'($urandom(32'h43b6));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rchk("stat", SSPS_ADDR_STAT, 8'hff, 8'h00);
		rchk("dir", SSPS_ADDR_DIR, 8'hff, SSPS_DIR_RESET);
		wr_reg(SSPS_ADDR_DIR, 8'h00);
		wr_reg(SSPS_ADDR_MASK, 8'h01);
		wr_reg(SSPS_ADDR_CTRL, 8'h20);
		for (int i = 0; i < 4; i++) begin
			// fastest divisor outruns the input synchroniser: steady peer data
			ptx = (i == 0) ? 8'hff : 8'($urandom);
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			wr_reg(SSPS_ADDR_BUF, d);
			if (i == 0) wr_reg(SSPS_ADDR_BUF, ~d);
			for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
			chk("irq", 8'h01, {7'h00, irq});
			chk("sck_oe", 8'h01, {7'h00, sck_oe});
			rchk("bf", SSPS_ADDR_STAT, 8'h01, 8'h01);
			rchk("rx", SSPS_ADDR_BUF, 8'hff, ptx);
			rchk("bf", SSPS_ADDR_STAT, 8'h01, 8'h00);
			chk("tx", d, prx);
			rchk("irqst", SSPS_ADDR_IRQ, 8'hff, irq_exp(i == 0));
			if (i == 0) rchk("wcol", SSPS_ADDR_CTRL, 8'h80, 8'h80);
			wr_reg(SSPS_ADDR_IRQ, 8'h07);
			wr_reg(SSPS_ADDR_CTRL, 8'h21);
			chk("irq", 8'h00, {7'h00, irq});
		end
		rchk("unmapped", 3'h6, 8'hff, 8'h00);
		wr_reg(SSPS_ADDR_MASK, 8'h00);
		wr_reg(SSPS_ADDR_BUF, 8'h5a);
		repeat (200) @(posedge clk);
		chk("masked", 8'h00, {7'h00, irq});
		rchk("irqst", SSPS_ADDR_IRQ, 8'h01, 8'h01);
		wr_reg(SSPS_ADDR_MASK, 8'h01);
		@(posedge clk);
		chk("unmask", 8'h01, {7'h00, irq});
		wr_reg(SSPS_ADDR_IRQ, 8'h01);
		rchk("drain", SSPS_ADDR_STAT, 8'h00, 8'h00);
		rchk("drain", SSPS_ADDR_BUF, 8'h00, 8'h00);
		wr_reg(SSPS_ADDR_CTRL, 8'h24);
		slv <= 1'b1;
		repeat (4) @(posedge clk);
		rchk("dir_hi", SSPS_ADDR_DIR, 8'h80, 8'h80);
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		rchk("dir_lo", SSPS_ADDR_DIR, 8'h80, 8'h00);
		chk("sdo_oe", 8'h01, {7'h00, sdo_oe});
		chk("slv_sck_oe", 8'h00, {7'h00, sck_oe});
		// slave shifts only once its buffer is loaded
		wr_reg(SSPS_ADDR_BUF, 8'h00);
		d = 8'($urandom);
		sbyte(d);
		repeat (8) @(posedge clk);
		rchk("sbf", SSPS_ADDR_STAT, 8'h01, 8'h01);
		rchk("srx", SSPS_ADDR_BUF, 8'hff, d);
		summarize();
	end
endmodule // ssps_spi_test
`default_nettype wire
